// file: design/hcdca_map.vh
// Constants for the hardcopy daisy-chain arbiter
`ifndef HCDCA_MAP_VH
`define HCDCA_MAP_VH
`define HCDCA_DIR_VECMODE   3'h2
`define HCDCA_DIR_MAIN      3'h6
`define HCDCA_CHAR_OFFSET   7'h3F
`define HCDCA_LAST_COLUMN   10'h2FF
`define HCDCA_READS         3'h6
`define HCDCA_LAST_LINE     8'hF0
`define HCDCA_BAND_HEIGHT   8'h0E
`define HCDCA_SCAN_STEP     8'h02
`define HCDCA_XOFF          8'h13
`define HCDCA_XON           8'h11
`define HCDCA_ESC           8'h1B
`define HCDCA_CHAR_P        8'h50
`define HCDCA_CHAR_1        8'h31
`define HCDCA_CHAR_Q        8'h71
`define HCDCA_CHAR_BSL      8'h5C
`define HCDCA_CHAR_K        8'h4B
`define HCDCA_BAUD_DIV      16'h0001
`define HCDCA_FORMAT        8'h4E
`endif

// file: design/hcdca_arbiter.v
// Hardcopy daisy-chain arbiter and graphic data sender
`timescale 1ns/10ps
`include "hcdca_map.vh"

module hcdca_arbiter (
  input  wire        clk,
  input  wire        rst,
  input  wire        hardcopyStart,
  input  wire        down_clear_in,
  input  wire        up_request_in,
  input  wire        up_rx_line,
  input  wire        down_tx_line,
  input  wire [3:0]  bitmapNibble,
  input  wire        bitmapValid,
  input  wire        txReady,
  input  wire [7:0]  rxByte,
  input  wire        rxValid,
  output reg         up_clear_out,
  output reg         down_request_out,
  output reg         up_tx_line,
  output reg         down_rx_line,
  output reg         bus_free_bit,
  output reg         dataSetReady,
  output reg         busy,
  output reg         rxInterrupt,
  output reg         bitmap_nibble_read,
  output reg  [9:0]  bitmapX,
  output reg  [7:0]  bitmapY,
  output reg         regWrite,
  output reg  [2:0]  regSelect,
  output reg  [15:0] regData,
  output reg         txWrite,
  output reg  [7:0]  txByte
);

  // ==========================================================
  // States
  localparam IDLE  = 4'h0;
  localparam CLAIM = 4'h1;
  localparam SETUP = 4'h2;
  localparam HEAD  = 4'h3;
  localparam READ  = 4'h4;
  localparam WAITR = 4'h5;
  localparam SEND  = 4'h6;
  localparam TAIL  = 4'h7;
  localparam DONE  = 4'h8;

  // ==========================================================
  // Pin synchronisers: three stages, change when stages 2 and 3 agree
  // Stages 2 and 3 must agree, so a one-cycle glitch never reaches the bus
  reg [2:0] clrSync;
  reg [2:0] reqSync;
  reg       clrLevel;
  reg       reqLevel;
  always @(posedge clk) begin
    if (rst) begin
      clrSync  <= 3'h0;
      reqSync  <= 3'h7;
      clrLevel <= 1'b0;
      reqLevel <= 1'b1;
    end else begin
      clrSync <= {clrSync[1:0], down_clear_in};
      reqSync <= {reqSync[1:0], up_request_in};
      if (clrSync[1] == clrSync[2])
        clrLevel <= clrSync[2];
      if (reqSync[1] == reqSync[2])
        reqLevel <= reqSync[2];
    end
  end

  // ==========================================================
  // Header and trailer sequence bytes
  function [7:0] seqByte;
    input [2:0] idx;
    input       tail;
    begin
      case ({tail, idx})
        4'h0:    seqByte = `HCDCA_ESC;
        4'h1:    seqByte = `HCDCA_CHAR_P;
        4'h2:    seqByte = `HCDCA_CHAR_1;
        4'h3:    seqByte = `HCDCA_CHAR_Q;
        4'h8:    seqByte = `HCDCA_ESC;
        4'h9:    seqByte = `HCDCA_CHAR_BSL;
        4'hA:    seqByte = `HCDCA_ESC;
        4'hB:    seqByte = `HCDCA_CHAR_K;
        default: seqByte = 8'h00;
      endcase
    end
  endfunction

  // ==========================================================
  // Transmit slot: buffer ready, printer not holding off, and no
  // byte written last cycle, so back-to-back writes never collide
  function canSend;
    input rdy;
    input hold;
    input justWrote;
    begin
      canSend = rdy & ~hold & ~justWrote;
    end
  endfunction

  // ==========================================================
  // Setup register values, in load order
  function [15:0] regValue;
    input [2:0] idx;
    begin
      case (idx)
        3'h0:    regValue = {13'h0000, `HCDCA_DIR_VECMODE};
        3'h1:    regValue = {13'h0000, `HCDCA_DIR_MAIN};
        3'h4:    regValue = `HCDCA_BAUD_DIV;
        3'h5:    regValue = {8'h00, `HCDCA_FORMAT};
        default: regValue = 16'h0000;
      endcase
    end
  endfunction

  // ==========================================================
  // Sequencer state
  reg [3:0] state;
  reg       requestToSend;
  reg       paused;
  reg [2:0] step;
  reg [2:0] readCount;
  reg [5:0] column;
  reg [7:0] bandBase;
  reg       pending;
  reg       sendLast;

  // ==========================================================
  // Chain pins and status bits
  always @(posedge clk) begin
    if (rst) begin
      up_clear_out     <= 1'b0;
      down_request_out <= 1'b1;
      up_tx_line       <= 1'b1;
      down_rx_line     <= 1'b1;
      bus_free_bit     <= 1'b1;
      dataSetReady     <= 1'b0;
    end else begin
      bus_free_bit <= ~clrLevel;
      dataSetReady <= ~reqLevel;
      // Active-low request-to-send; lockout from either side forwarded
      up_clear_out     <= ~requestToSend | clrLevel;
      down_request_out <= requestToSend & reqLevel;
      // Upstream traffic passes toward printer in every state; own data goes out on txByte
      up_tx_line   <= down_tx_line;
      down_rx_line <= up_rx_line;
    end
  end

  // ==========================================================
  // Hardcopy sequencer
  always @(posedge clk) begin
    if (rst) begin
      state              <= IDLE;
      requestToSend      <= 1'b1;
      paused             <= 1'b0;
      step               <= 3'h0;
      readCount          <= 3'h0;
      column             <= 6'h00;
      bandBase           <= 8'h00;
      pending            <= 1'b0;
      sendLast           <= 1'b0;
      rxInterrupt        <= 1'b0;
      bitmap_nibble_read <= 1'b0;
      bitmapX            <= 10'h000;
      bitmapY            <= 8'h00;
      regWrite           <= 1'b0;
      regSelect          <= 3'h0;
      regData            <= 16'h0000;
      txWrite            <= 1'b0;
      txByte             <= 8'h00;
    end else begin
      regWrite           <= 1'b0;
      txWrite            <= 1'b0;
      bitmap_nibble_read <= 1'b0;
      rxInterrupt        <= 1'b0;
      if (rxValid && rxByte == `HCDCA_XOFF) begin
        paused      <= 1'b1;
        rxInterrupt <= 1'b1;
      end else if (rxValid && rxByte == `HCDCA_XON)
        paused <= 1'b0;
      case (state)
        IDLE: begin
          if (hardcopyStart && !pending)
            pending <= 1'b1;
          if (pending)
            state <= CLAIM;
        end
        CLAIM: begin
          // Upstream holds lockout longer, so farthest wins
          if (bus_free_bit && !dataSetReady) begin
            requestToSend <= 1'b0;
            step          <= 3'h0;
            state         <= SETUP;
          end
        end
        SETUP: begin
          regWrite  <= 1'b1;
          regSelect <= step;
          regData   <= regValue(step);
          step <= step + 3'h1;
          if (step == 3'h5) begin
            step     <= 3'h0;
            bandBase <= 8'h00;
            state    <= HEAD;
          end
        end
        HEAD, TAIL: begin
          // Frame each band; trailer is terminator then line-down
          if (canSend(txReady, paused, txWrite)) begin
            txWrite <= 1'b1;
            txByte  <= seqByte({1'b0, step[1:0]}, state == TAIL);
            step    <= step + 3'h1;
            if (step == 3'h3) begin
              step      <= 3'h0;
              bitmapX   <= 10'h000;
              readCount <= 3'h0;
              column    <= 6'h00;
              if (state == HEAD)
                state <= READ;
              else if (bandBase >= `HCDCA_LAST_LINE - `HCDCA_BAND_HEIGHT)
                state <= DONE;
              else begin
                bandBase <= bandBase + `HCDCA_BAND_HEIGHT;
                state    <= HEAD;
              end
            end
          end
        end
        READ: begin
          bitmap_nibble_read <= 1'b1;
          bitmapY <= bandBase + {4'h0, readCount, 1'b0};
          state   <= WAITR;
        end
        WAITR: begin
          if (bitmapValid) begin
            column[readCount] <= bitmapNibble[0];
            readCount         <= readCount + 3'h1;
            state             <= (readCount == `HCDCA_READS - 3'h1) ?
                                 SEND : READ;
          end
        end
        SEND: begin
          // Pause is checked each byte; one in flight may still finish
          if (canSend(txReady, paused, txWrite)) begin
            txWrite   <= 1'b1;
            txByte    <= {2'h0, column} + {1'b0, `HCDCA_CHAR_OFFSET};
            readCount <= 3'h0;
            column    <= 6'h00;
            sendLast  <= (bitmapX == `HCDCA_LAST_COLUMN);
            if (bitmapX == `HCDCA_LAST_COLUMN)
              state <= TAIL;
            else begin
              bitmapX <= bitmapX + 10'h001;
              state   <= READ;
            end
          end
        end
        DONE: begin
          requestToSend <= 1'b1;
          pending       <= 1'b0;
          state         <= IDLE;
        end
        default: state <= IDLE;
      endcase
    end
  end

  // ==========================================================
  // Busy level: up from an accepted start until the bus is freed
  // Kept apart from the sequencer so it cannot drop between states
  always @(posedge clk) begin
    if (rst)
      busy <= 1'b0;
    else if (state == DONE)
      busy <= 1'b0;
    else if (hardcopyStart || pending)
      busy <= 1'b1;
  end

endmodule

// file: bench/hcdca_properties.sv
// Assertion checker for the hardcopy daisy-chain arbiter
`timescale 1ns/10ps
module hcdca_properties (
  input wire        clk,
  input wire        rst,
  input wire        down_clear_in,
  input wire        up_request_in,
  input wire [7:0]  rxByte,
  input wire        rxValid,
  input wire        up_clear_out,
  input wire        down_request_out,
  input wire        bus_free_bit,
  input wire        dataSetReady,
  input wire        rxInterrupt,
  input wire        bitmap_nibble_read,
  input wire [7:0]  bitmapY,
  input wire        regWrite,
  input wire [2:0]  regSelect,
  input wire [15:0] regData,
  input wire        txWrite
);
  // ======
  // Pause state as last asked for by the printer
  reg paused;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always @(posedge clk)
    if (rst || (rxValid && rxByte == 8'h11))
      paused <= 1'b0;
    else if (rxValid && rxByte == 8'h13)
      paused <= 1'b1;
  chk_free_bit: assert property (
    $stable(down_clear_in) [*6] |-> bus_free_bit == !down_clear_in)
    else $error("bus free bit wrong");
  chk_dsr_bit: assert property (
    $stable(up_request_in) [*6] |-> dataSetReady == !up_request_in)
    else $error("ready bit wrong");
  chk_tx_owner: assert property (
    txWrite |-> up_clear_out && !down_request_out)
    else $error("byte sent without bus");
  chk_setup_order: assert property (
    regWrite && regSelect < 3'h5 |=>
      regWrite && regSelect == $past(regSelect) + 3'h1)
    else $error("setup order wrong");
  chk_setup_dir: assert property (
    regWrite && regSelect < 3'h2 |->
      regData == (regSelect[0] ? 16'h0006 : 16'h0002))
    else $error("direction value wrong");
  chk_xoff_irq: assert property (
    rxValid && rxByte == 8'h13 |-> ##[1:2] rxInterrupt)
    else $error("no interrupt on pause");
  chk_xoff_hold: assert property (
    paused && $past(paused) |-> !txWrite)
    else $error("byte sent while paused");
  chk_read_line: assert property (
    bitmap_nibble_read |-> !bitmapY[0] ##1 !bitmap_nibble_read)
    else $error("bad bit map read");
endmodule
bind hcdca_arbiter hcdca_properties i_chk (
  .clk, .rst, .down_clear_in, .up_request_in, .rxByte, .rxValid,
  .up_clear_out, .down_request_out, .bus_free_bit, .dataSetReady,
  .rxInterrupt, .bitmap_nibble_read, .bitmapY, .regWrite,
  .regSelect, .regData, .txWrite);

// file: bench/hcdca_printer.sv
// Printer model: buffers characters, paces with XOFF and XON
`timescale 1ns/10ps
module hcdca_printer #(parameter DEPTH = 256) (
  input  wire       clk,
  input  wire       rst,
  input  wire       txWrite,
  input  wire [7:0] txByte,
  output wire       txReady,
  output reg  [7:0] rxByte,
  output reg        rxValid
);
  // ======
  // Drains one byte each 64 cycles so a fast sender must be held off
  reg [8:0] fill;
  reg [5:0] tick;
  reg [5:0] last;
  reg       held;
  wire      drain = tick == 6'h00 && fill != 9'h000;
  assign txReady = tick[0];
  always @(posedge clk) begin
    rxValid <= 1'b0;
    rxByte <= ~rxByte;
    tick <= tick + 6'h01;
    fill <= fill + {8'h00, txWrite} - {8'h00, drain};
    if (txWrite)
      last <= txByte[5:0] - 6'h3F;
    if (!held && fill >= DEPTH - 2) begin
      {held, rxValid, rxByte} <= {2'h3, 8'h13};
    end else if (held && fill <= DEPTH / 2) begin
      {held, rxValid, rxByte} <= {2'h1, 8'h11};
    end
    if (rst) begin
      {fill, tick, held, rxByte} <= 24'h000000;
    end
  end
endmodule

// file: bench/hcdca_arbiter_tb.sv
// Self-checking testbench for the hardcopy daisy-chain arbiter
`timescale 1ns/10ps
module hcdca_arbiter_tb;
  // ======
  reg         clk, rst, hardcopyStart, down_clear_in, up_request_in;
  reg         up_rx_line, down_tx_line, bitmapValid;
  reg  [3:0]  bitmapNibble, nib;
  wire        up_clear_out, down_request_out, up_tx_line, down_rx_line;
  wire        bus_free_bit, dataSetReady, busy, rxInterrupt, txReady;
  wire        bitmap_nibble_read, regWrite, txWrite, rxValid;
  wire [9:0]  bitmapX;
  wire [7:0]  bitmapY, txByte, rxByte;
  wire [2:0]  regSelect;
  wire [15:0] regData;
  reg  [31:0] seed, mseed;
  reg  [15:0] setup [0:7];
  reg  [7:0]  sent [0:63];
  reg  [5:0]  col;
  integer     errTotal, numChecks, nSetup, nSent, nIrq, i, n;
  hcdca_arbiter i_dut (.clk, .rst, .hardcopyStart, .down_clear_in,
    .up_request_in, .up_rx_line, .down_tx_line, .bitmapNibble,
    .bitmapValid, .txReady, .rxByte, .rxValid, .up_clear_out,
    .down_request_out, .up_tx_line, .down_rx_line, .bus_free_bit,
    .dataSetReady, .busy, .rxInterrupt, .bitmap_nibble_read, .bitmapX,
    .bitmapY, .regWrite, .regSelect, .regData, .txWrite, .txByte);
  hcdca_printer #(.DEPTH(8)) i_prn (.clk, .rst, .txWrite, .txByte,
    .txReady, .rxByte, .rxValid);
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function pix(input [9:0] x, input [7:0] y);
    pix = x[0] ^ x[3] ^ y[1] ^ y[2] ^ y[3];
  endfunction
  task check(input [15:0] got, input [15:0] exp);
    begin
      numChecks = numChecks + 1;
      if (got !== exp) begin
        errTotal = errTotal + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task printVerdict;
    begin
      $display("checks %0d errors %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task step(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    nIrq = nIrq + rxInterrupt;
    if (regWrite) begin
      setup[regSelect] = regData;
      nSetup = nSetup + 1;
    end
    if (txWrite && nSent < 64) begin
      sent[nSent] = txByte;
      nSent = nSent + 1;
    end
  end
  // Bit-map memory answers each read after one to four cycles
  initial begin
    {bitmapValid, bitmapNibble, mseed} = {5'h00, 32'h4FE6};
    forever begin
      step(1);
      while (bitmap_nibble_read) begin
        mseed = lfsr(mseed);
        nib = {mseed[3:1], pix(bitmapX, bitmapY)};
        step(1 + mseed[5:4]);
        {bitmapValid, bitmapNibble} = {1'b1, nib};
        step(1);
        bitmapValid = 1'b0;
      end
    end
  end
  initial begin
    {rst, hardcopyStart, down_clear_in, up_request_in} = 4'h9;
    {up_rx_line, down_tx_line, seed} = {2'h3, 32'h4FE6};
    {errTotal, numChecks, nSetup, nSent, nIrq} = 160'h0;
    step(4);
    rst = 1'b0;
    check({12'h000, up_clear_out, down_request_out, bus_free_bit,
      dataSetReady}, 16'h0006);
    for (i = 0; i < 8; i = i + 1) begin
      seed = lfsr(seed);
      {up_rx_line, down_tx_line} = seed[1:0];
      step(1);
      check({14'h0, up_tx_line, down_rx_line}, {14'h0, seed[0], seed[1]});
    end
    {up_rx_line, down_tx_line, down_clear_in, up_request_in} = 4'hE;
    step(8);
    hardcopyStart = 1'b1;
    step(1);
    hardcopyStart = 1'b0;
    step(8);
    check({12'h000, bus_free_bit, dataSetReady, up_clear_out,
      down_request_out}, 16'h0006);
    up_request_in = 1'b1;
    step(8);
    check(nSetup[15:0], 16'h0000);
    down_clear_in = 1'b0;
    // A second start mid-dump must be ignored
    for (n = 0; nSent < 44 && n < 20000; n = n + 1) begin
      hardcopyStart = n == 300;
      step(1);
    end
    if (n == 20000)
      errTotal = errTotal + 1;
    check(nSetup[15:0], 16'h0006);
    check(setup[0], 16'h0002);
    check(setup[1], 16'h0006);
    check({13'h0, up_clear_out, down_request_out, busy}, 16'h0005);
    check({15'h0, nIrq > 0}, 16'h0001);
    check({sent[0], sent[1]}, 16'h1B50);
    check({sent[2], sent[3]}, 16'h3171);
    for (i = 0; i < 40; i = i + 1) begin
      for (n = 0; n < 6; n = n + 1)
        col[n] = pix(i[9:0], {n[6:0], 1'b0});
      check({8'h00, sent[i + 4]}, {8'h00, col + 8'h3F});
    end
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    check({11'h0, up_clear_out, down_request_out, busy, regWrite,
      txWrite}, 16'h0008);
    printVerdict;
  end
endmodule
